// ==== hdl/stop_wake_ctrl.v ====
// Notes on behaviour
// - irq0 comes from port3 bit3 in digital mode, from wake logic in analog.
// - six maskable prioritized requests: three port3, two timers, one low voltage.
// - mask register enables each request and has a global enable gate.
// - control bit d0 divides system and timer clock by sixteen.
// - divide select clears on every stop-mode recovery.
// - control bits d2-d4 choose the wake source.
// - second register bit 6 selects wake level, low after reset.
// - codes 011-111 use nor or nand of port3, port0 and port2 pins.
// - pins configured as outputs are ignored by wake logic.
// - either register's wake event ends stop mode.
// - source and level of second register are write-only, read zero.
`timescale 1ns/1ps
`include "stop_wake_defines.vh"
module stop_wake_ctrl #(
  parameter DIV_RATIO = `DIV_RATIO
) (
  input wire SYS_CLK,
  input wire RST_B,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output wire PREADY,
  output wire PSLVERR,
  output reg [31:0] PRDATA,
  input wire [7:0] PORT0_IN,
  input wire [7:0] PORT2_IN,
  input wire [3:0] PORT3_IN,
  input wire [1:0] TIMER_IRQ,
  input wire LOW_VOLTAGE_FLAG,
  input wire STOP_MODE,
  input wire GLOBAL_EI,
  input wire GLOBAL_DI,
  output reg STOP_EXIT,
  output reg SCLK_EN,
  output reg TIMER_CLK_EN,
  output reg IRQ_OUT,
  output reg [2:0] IRQ_VECTOR
);

  ////////////////////////////////////////////////////////////////////
  reg [7:0] stop_wake_control;
  reg [7:0] stop_wake_control_two;
  reg [7:0] port3_mode_register;
  reg [7:0] interrupt_mask_register;
  reg [5:0] irq_req;
  reg [15:0] port_dir;
  reg wake_meta;
  reg wake_sync;
  reg wake_prev;
  reg p33_prev;
  reg [3:1] p3_prev;
  reg [3:0] div_cnt;
  wire wake_a;
  wire wake_b;
  wire wr;
  wire rd;
  wire mapped;
  wire wake_any;
  wire irq0_edge;
  wire [5:0] irq_set;
  wire [5:0] irq_pend;
  reg [2:0] next_vector;
  integer i;

  function sel_addr;
    input [11:0] a;
    input [11:0] b;
    begin
      sel_addr = (a == b);
    end
  endfunction

  assign PREADY = 1'b1;
  assign wr = PSEL & PENABLE & PWRITE;
  assign rd = PSEL & ~PWRITE;
  assign mapped = sel_addr(PADDR, `ADDR_WAKE_CTRL) | sel_addr(PADDR, `ADDR_WAKE_CTRL_TWO) |
    sel_addr(PADDR, `ADDR_PORT3_MODE) | sel_addr(PADDR, `ADDR_IRQ_MASK) |
    sel_addr(PADDR, `ADDR_IRQ_REQ) | sel_addr(PADDR, `ADDR_PORT_DIR);
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  ////////////////////////////////////////////////////////////////////
  // two copies of the source decoder, one per control register
  wake_source_select u_wake_a (
    .src(stop_wake_control[`WC_SRC_LSB+2:`WC_SRC_LSB]),
    .level_high(1'b0),
    .port0_in(PORT0_IN),
    .port2_in(PORT2_IN),
    .port3_in(PORT3_IN),
    .port0_out_en(port_dir[7:0]),
    .port2_out_en(port_dir[15:8]),
    .wake(wake_a)
  );

  wake_source_select u_wake_b (
    .src(stop_wake_control_two[`WC2_SRC_LSB+2:`WC2_SRC_LSB]),
    .level_high(stop_wake_control_two[`WC2_LEVEL_BIT]),
    .port0_in(PORT0_IN),
    .port2_in(PORT2_IN),
    .port3_in(PORT3_IN),
    .port0_out_en(port_dir[7:0]),
    .port2_out_en(port_dir[15:8]),
    .wake(wake_b)
  );

  assign wake_any = wake_a | wake_b;

  ////////////////////////////////////////////////////////////////////
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      stop_wake_control <= `WAKE_CTRL_RST;
      stop_wake_control_two <= `WAKE_CTRL_TWO_RST;
      port3_mode_register <= `PORT3_MODE_RST;
      interrupt_mask_register <= `IRQ_MASK_RST;
      port_dir <= 16'h0000;
      STOP_EXIT <= 1'b0;
    end else begin
      STOP_EXIT <= STOP_MODE & wake_any;
      if (wr && sel_addr(PADDR, `ADDR_WAKE_CTRL)) begin
        stop_wake_control <= PWDATA[7:0];
      end
      if (wr && sel_addr(PADDR, `ADDR_WAKE_CTRL_TWO)) begin
        stop_wake_control_two <= PWDATA[7:0] & 8'h5C;
      end
      if (wr && sel_addr(PADDR, `ADDR_PORT3_MODE)) begin
        port3_mode_register <= PWDATA[7:0];
      end
      if (wr && sel_addr(PADDR, `ADDR_PORT_DIR)) begin
        port_dir <= PWDATA[15:0];
      end
      // global enable moves only through the instruction strobes
      if (wr && sel_addr(PADDR, `ADDR_IRQ_MASK)) begin
        interrupt_mask_register[5:0] <= PWDATA[5:0];
      end
      if (GLOBAL_DI) begin
        interrupt_mask_register[`IMR_GLOBAL_BIT] <= 1'b0;
      end else if (GLOBAL_EI) begin
        interrupt_mask_register[`IMR_GLOBAL_BIT] <= 1'b1;
      end
      // recovery wins over a same-cycle write of the divide bit
      if (STOP_MODE && wake_any) begin
        stop_wake_control[`WC_DIV16_BIT] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // clock prescaler: enables replace a gated clock
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      div_cnt <= 4'h0;
      SCLK_EN <= 1'b1;
      TIMER_CLK_EN <= 1'b1;
    end else begin
      div_cnt <= (div_cnt == DIV_RATIO - 1) ? 4'h0 : div_cnt + 4'h1;
      if (stop_wake_control[`WC_DIV16_BIT]) begin
        SCLK_EN <= (div_cnt == DIV_RATIO - 1);
        TIMER_CLK_EN <= (div_cnt == DIV_RATIO - 1);
      end else begin
        SCLK_EN <= 1'b1;
        TIMER_CLK_EN <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // wake output is asynchronous in stop, so it gets two flops first
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
      wake_prev <= 1'b0;
      p33_prev <= 1'b0;
      p3_prev <= 3'h0;
    end else begin
      wake_meta <= wake_any;
      wake_sync <= wake_meta;
      wake_prev <= wake_sync;
      p33_prev <= PORT3_IN[3];
      p3_prev <= PORT3_IN[3:1];
    end
  end

  assign irq0_edge = port3_mode_register[`P3M_ANALOG_BIT] ?
    (wake_sync & ~wake_prev) :
    (~PORT3_IN[3] & p33_prev);
  // falling edges on p32, p31 and timer/low-voltage events
  assign irq_set = {LOW_VOLTAGE_FLAG, TIMER_IRQ, ~PORT3_IN[1] & p3_prev[1],
    ~PORT3_IN[2] & p3_prev[2], irq0_edge};

  ////////////////////////////////////////////////////////////////////
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_req <= 6'h00;
    end else begin
      // set beats a software clear in the same cycle
      if (wr && sel_addr(PADDR, `ADDR_IRQ_REQ)) begin
        irq_req <= PWDATA[5:0] | irq_set;
      end else begin
        irq_req <= irq_req | irq_set;
      end
    end
  end

  assign irq_pend = irq_req & interrupt_mask_register[5:0] &
    {6{interrupt_mask_register[`IMR_GLOBAL_BIT]}};

  always @* begin
    next_vector = 3'h0;
    for (i = 5; i >= 0; i = i - 1) begin
      if (irq_pend[i]) begin
        next_vector = i[2:0];
      end
    end
  end

  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      IRQ_OUT <= 1'b0;
      IRQ_VECTOR <= 3'h0;
    end else begin
      IRQ_OUT <= |irq_pend;
      IRQ_VECTOR <= next_vector;
    end
  end

  ////////////////////////////////////////////////////////////////////
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA <= 32'h00000000;
    end else if (rd && !PENABLE) begin
      PRDATA <= 32'h00000000;
      if (sel_addr(PADDR, `ADDR_WAKE_CTRL)) begin
        PRDATA <= {24'h000000, stop_wake_control};
      end
      if (sel_addr(PADDR, `ADDR_WAKE_CTRL_TWO)) begin
        PRDATA <= 32'h00000000;
      end
      if (sel_addr(PADDR, `ADDR_PORT3_MODE)) begin
        PRDATA <= {24'h000000, port3_mode_register};
      end
      if (sel_addr(PADDR, `ADDR_IRQ_MASK)) begin
        PRDATA <= {24'h000000, interrupt_mask_register};
      end
      if (sel_addr(PADDR, `ADDR_IRQ_REQ)) begin
        PRDATA <= {26'h0000000, irq_req};
      end
      if (sel_addr(PADDR, `ADDR_PORT_DIR)) begin
        PRDATA <= {16'h0000, port_dir};
      end
    end
  end

endmodule

// ==== hdl/stop_wake_defines.vh ====
`ifndef STOP_WAKE_DEFINES_VH
`define STOP_WAKE_DEFINES_VH

// apb byte addresses (registers are not word aligned in their own space)
`define IDX_WAKE_CTRL 8'h0B
`define IDX_WAKE_CTRL_TWO 8'h0D
`define IDX_PORT3_MODE 8'h03
`define IDX_IRQ_MASK 8'hFB
`define IDX_IRQ_REQ 8'hFA
`define IDX_PORT_DIR 8'h10
`define ADDR_WAKE_CTRL 12'h02C
`define ADDR_WAKE_CTRL_TWO 12'h034
`define ADDR_PORT3_MODE 12'h00C
`define ADDR_IRQ_MASK 12'h3EC
`define ADDR_IRQ_REQ 12'h3E8
`define ADDR_PORT_DIR 12'h040

// field positions
`define WC_DIV16_BIT 0
`define WC_SRC_LSB 2
`define WC2_LEVEL_BIT 6
`define WC2_SRC_LSB 2
`define P3M_ANALOG_BIT 1
`define IMR_GLOBAL_BIT 7

// reset values
`define WAKE_CTRL_RST 8'h00
`define WAKE_CTRL_TWO_RST 8'h00
`define PORT3_MODE_RST 8'h00
`define IRQ_MASK_RST 8'h00

// timing
`define DIV_RATIO 16
`define NUM_IRQ 6

`endif

// ==== hdl/wake_source_select.v ====
`timescale 1ns/1ps
module wake_source_select (
  input wire [2:0] src,
  input wire level_high,
  input wire [7:0] port0_in,
  input wire [7:0] port2_in,
  input wire [3:0] port3_in,
  input wire [7:0] port0_out_en,
  input wire [7:0] port2_out_en,
  output reg wake
);
  // output pins are forced to the non-asserting value of each gate
  wire [7:0] p0 = port0_in;
  wire [7:0] p2 = port2_in;
  wire [3:1] p3 = port3_in[3:1];
  reg [7:0] nand_in;
  reg [7:0] nor_in;
  reg [7:0] excl;
  reg raw;
  always @* begin
    nand_in = 8'hFF;
    nor_in = 8'h00;
    excl = 8'h00;
    raw = 1'b0;
    case (src)
      3'h1: begin
        nand_in = {4'hF, p2[3:0] | port2_out_en[3:0]};
        raw = ~&nand_in;
      end
      3'h2: begin
        nand_in = p2 | port2_out_en;
        raw = ~&nand_in;
      end
      3'h3: begin
        raw = ~|p3;
      end
      3'h4: begin
        raw = ~&p3;
      end
      3'h5: begin
        nor_in = {5'h00, p3[3:1]};
        excl = {p0[7] & ~port0_out_en[7], p0[0] & ~port0_out_en[0], 6'h00};
        raw = ~(|nor_in | |excl);
      end
      3'h6: begin
        nand_in = {4'hF, p3[3:1], 1'b1};
        excl = {6'h3F, p0[7] | port0_out_en[7], p0[0] | port0_out_en[0]};
        raw = ~(&nand_in & &excl);
      end
      3'h7: begin
        nand_in = {2'h3, p3[3:1], p2[2:0] | port2_out_en[2:0]};
        raw = ~&nand_in;
      end
      default: begin
        raw = 1'b0;
      end
    endcase
    // gate output is low on wake; level bit flips polarity at the xor
    wake = (src == 3'h0) ? 1'b0 : (raw ^ ~level_high);
  end
endmodule

// ==== dv/stop_wake_checker.sv ====
`timescale 1ns/1ps
`include "stop_wake_defines.vh"
module stop_wake_checker #(
  parameter DIV_RATIO = 16
) (
  input wire SYS_CLK,
  input wire RST_B,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire PREADY,
  input wire PSLVERR,
  input wire [31:0] PRDATA,
  input wire STOP_MODE,
  input wire GLOBAL_DI,
  input wire STOP_EXIT,
  input wire SCLK_EN,
  input wire TIMER_CLK_EN,
  input wire IRQ_OUT,
  input wire [2:0] IRQ_VECTOR
);
  wire acc = PSEL && PENABLE;
  wire hit = PADDR == `ADDR_WAKE_CTRL || PADDR == `ADDR_WAKE_CTRL_TWO ||
    PADDR == `ADDR_PORT3_MODE || PADDR == `ADDR_IRQ_MASK || PADDR == `ADDR_IRQ_REQ ||
    PADDR == `ADDR_PORT_DIR;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  AST_PREADY: assert property (PREADY) else $error("pready low");
  AST_SLV_MAP: assert property (acc && hit |-> !PSLVERR) else $error("pslverr on mapped");
  AST_SLV_UNMAP: assert property (acc && !hit |-> PSLVERR) else $error("no pslverr");
  AST_WC2_RD: assert property (acc && !PWRITE && PADDR == `ADDR_WAKE_CTRL_TWO
    |-> PRDATA == 32'h0) else $error("wake control two readable");
  AST_EXIT_STOP: assert property (STOP_EXIT |-> $past(STOP_MODE))
    else $error("exit outside stop");
  AST_DIV_CLR: assert property (STOP_EXIT |-> ##[1:3] SCLK_EN [*2])
    else $error("divide not cleared");
  AST_CLK_PAIR: assert property (TIMER_CLK_EN == SCLK_EN) else $error("clock enables differ");
  AST_DI_OFF: assert property (GLOBAL_DI |-> ##[1:2] !IRQ_OUT) else $error("irq after di");
  AST_VEC: assert property (IRQ_VECTOR < 3'h6) else $error("vector range");
  cover property ($rose(STOP_EXIT));
  cover property ($fell(SCLK_EN));
  cover property (acc && PSLVERR);
  cover property ($rose(IRQ_OUT));
endmodule
bind stop_wake_ctrl stop_wake_checker #(.DIV_RATIO(DIV_RATIO)) chk (.SYS_CLK(SYS_CLK),
  .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA), .STOP_MODE(STOP_MODE),
  .GLOBAL_DI(GLOBAL_DI), .STOP_EXIT(STOP_EXIT), .SCLK_EN(SCLK_EN),
  .TIMER_CLK_EN(TIMER_CLK_EN), .IRQ_OUT(IRQ_OUT), .IRQ_VECTOR(IRQ_VECTOR));

// ==== dv/port_pins.sv ====
`timescale 1ns/1ps
module port_pins (
  output reg [7:0] p0,
  output reg [7:0] p2,
  output reg [3:0] p3
);
  initial {p0, p2, p3} = 20'h00000;
  // pins are driven levels; call only right after a clock edge
  task set(input [7:0] a, input [7:0] b, input [3:0] c);
    p0 <= a;
    p2 <= b;
    p3 <= c;
  endtask
endmodule

// ==== dv/stop_wake_ctrl_tb.sv ====
`timescale 1ns/1ps
`include "stop_wake_defines.vh"
module stop_wake_ctrl_tb;
  reg SYS_CLK = 0, RST_B = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  reg STOP_MODE = 0, GLOBAL_EI = 0, GLOBAL_DI = 0, LOW_VOLTAGE_FLAG = 0;
  reg [11:0] PADDR = 12'h000;
  reg [31:0] PWDATA = 32'h0;
  reg [1:0] TIMER_IRQ = 2'h0;
  wire PREADY, PSLVERR, STOP_EXIT, SCLK_EN, TIMER_CLK_EN, IRQ_OUT;
  wire [31:0] PRDATA;
  wire [2:0] IRQ_VECTOR;
  wire [7:0] p0, p2;
  wire [3:0] p3;
  int n_fail = 0, num_checks = 0;
  reg [31:0] rd;
  reg er;
  always #5 SYS_CLK = ~SYS_CLK;
  port_pins pins (.p0(p0), .p2(p2), .p3(p3));
  stop_wake_ctrl #(.DIV_RATIO(16)) dut (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PRDATA(PRDATA), .PORT0_IN(p0), .PORT2_IN(p2), .PORT3_IN(p3),
    .TIMER_IRQ(TIMER_IRQ), .LOW_VOLTAGE_FLAG(LOW_VOLTAGE_FLAG), .STOP_MODE(STOP_MODE),
    .GLOBAL_EI(GLOBAL_EI), .GLOBAL_DI(GLOBAL_DI), .STOP_EXIT(STOP_EXIT), .SCLK_EN(SCLK_EN),
    .TIMER_CLK_EN(TIMER_CLK_EN), .IRQ_OUT(IRQ_OUT), .IRQ_VECTOR(IRQ_VECTOR));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // request held until pready is sampled high; data taken at that edge
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  task wt(input sel, input [31:0] exp);
    repeat (4) @(posedge SYS_CLK);
    for (int i = 0; i < 12 && (sel ? IRQ_OUT : STOP_EXIT) !== exp[0]; i++) @(posedge SYS_CLK);
  endtask
  task pulse(input di);
    @(posedge SYS_CLK);
    if (di) GLOBAL_DI <= 1; else GLOBAL_EI <= 1;
    @(posedge SYS_CLK);
    GLOBAL_DI <= 0;
    GLOBAL_EI <= 0;
  endtask
  task sclk_count(input int len, input [31:0] exp);
    int n;
    n = 0;
    repeat (len) begin
      @(posedge SYS_CLK);
      if (SCLK_EN === 1'b1) n++;
    end
    chk("sclk_en count", exp, n);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    apb(1, `ADDR_WAKE_CTRL_TWO, 32'h5C);
    apb(0, `ADDR_WAKE_CTRL_TWO, 0);
    chk("wake two read", 0, rd);
    apb(1, 12'h100, 32'hFF);
    chk("unmapped err", 1, er);
    apb(0, 12'h100, 0);
    chk("unmapped read", 0, rd);
    $display("test regs done");
  endtask
  task t_wake;
    apb(1, `ADDR_WAKE_CTRL, 32'h01);
    // the first enable after the write still comes from the undivided setting
    @(posedge SYS_CLK);
    sclk_count(160, 10);
    for (int c = 1; c < 8; c++) begin
      @(posedge SYS_CLK);
      pins.set(8'hFF, 8'hFF, 4'hF);
      apb(1, `ADDR_WAKE_CTRL_TWO, 32'h40 | (c << 2));
      STOP_MODE <= 1;
      wt(0, 0);
      chk("exit idle", 0, STOP_EXIT);
      pins.set(8'h00, 8'h00, 4'h0);
      wt(0, 1);
      chk("exit wake", 1, STOP_EXIT);
      STOP_MODE <= 0;
    end
    sclk_count(32, 32);
    apb(1, `ADDR_WAKE_CTRL_TWO, 32'h0C);
    pins.set(8'hFF, 8'hFF, 4'hF);
    STOP_MODE <= 1;
    wt(0, 1);
    chk("low level wake", 1, STOP_EXIT);
    STOP_MODE <= 0;
    apb(1, `ADDR_PORT_DIR, 32'hFFFF);
    apb(1, `ADDR_WAKE_CTRL_TWO, 32'h44);
    pins.set(8'h00, 8'h00, 4'hF);
    STOP_MODE <= 1;
    wt(0, 0);
    chk("output pin ignored", 0, STOP_EXIT);
    STOP_MODE <= 0;
    apb(1, `ADDR_PORT_DIR, 32'h0);
    $display("test wake done");
  endtask
  task t_irq;
    pins.set(8'hFF, 8'hFF, 4'h8);
    pulse(1);
    apb(1, `ADDR_IRQ_MASK, 32'h3F);
    apb(1, `ADDR_IRQ_REQ, 32'h0);
    pulse(0);
    pins.set(8'hFF, 8'hFF, 4'h0);
    wt(1, 1);
    chk("irq digital", 1, IRQ_OUT);
    chk("vector p3 bit3", 0, IRQ_VECTOR);
    apb(1, `ADDR_IRQ_REQ, 32'h0);
    TIMER_IRQ <= 2'h2;
    LOW_VOLTAGE_FLAG <= 1;
    wt(1, 1);
    chk("vector timer", 4, IRQ_VECTOR);
    TIMER_IRQ <= 2'h0;
    LOW_VOLTAGE_FLAG <= 0;
    pulse(1);
    apb(1, `ADDR_IRQ_REQ, 32'h01);
    wt(1, 0);
    chk("global off", 0, IRQ_OUT);
    apb(1, `ADDR_IRQ_REQ, 32'h0);
    apb(1, `ADDR_PORT3_MODE, 32'h02);
    apb(1, `ADDR_WAKE_CTRL_TWO, 32'h44);
    pulse(0);
    pins.set(8'hFF, 8'h00, 4'h0);
    wt(1, 1);
    chk("irq analog", 1, IRQ_OUT);
    chk("vector analog", 0, IRQ_VECTOR);
    $display("test irq done");
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge SYS_CLK);
    RST_B <= 1;
    t_regs;
    t_wake;
    t_irq;
    summarize;
  end
  // the tests need well under a thousand cycles; thirty thousand cycles means a hang
  initial begin
    #300000;
    n_fail++;
    summarize;
  end
endmodule
